// [src/lbe_ctrl.sv]
// Local bus RAM controller: four local bus ports onto one RAM port with
// check byte, plus the error register bank behind a lite register bus.
// Assumes a synchronous RAM with one cycle read latency on sys_clk.
`timescale 1ns/1ps
module lbe_ctrl (
  input logic sys_clk,
  input logic rst,
  input lbe_pkg::lbe_req_t [lbe_pkg::NPORT-1:0] local_bus_req,
  output logic [lbe_pkg::NPORT-1:0][lbe_pkg::DW-1:0] port_read_data,
  output logic [lbe_pkg::NPORT-1:0] port_ready,
  output logic [lbe_pkg::NPORT-1:0] port_wait,
  output logic [lbe_pkg::NPORT-1:0] port_correctable_flag,
  output logic [lbe_pkg::NPORT-1:0] port_uncorrectable_flag,
  output logic mem_en,
  output logic [lbe_pkg::NLANE-1:0] mem_we,
  output logic [lbe_pkg::AW-1:0] mem_addr,
  output logic [lbe_pkg::MW-1:0] mem_dout,
  input logic [lbe_pkg::MW-1:0] mem_din,
  output logic interrupt,
  output logic uncorrectable_error_pulse,
  output logic correctable_error_pulse,
  input logic [lbe_pkg::RAW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [lbe_pkg::DW-1:0] s_axi_wdata,
  input logic [lbe_pkg::BEW-1:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [lbe_pkg::RAW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [lbe_pkg::DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready
);

  function automatic logic [lbe_pkg::NPORT-1:0] lbe_onehot(
      input logic [lbe_pkg::PSW-1:0] p);
    return lbe_pkg::NPORT'(1) << p;
  endfunction : lbe_onehot

  function automatic logic [lbe_pkg::DW-1:0] lbe_byte_mask(
      input logic [lbe_pkg::BEW-1:0] be);
    logic [lbe_pkg::DW-1:0] m;
    for (int i = 0; i < lbe_pkg::BEW; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lbe_byte_mask

  function automatic logic [1:0] lbe_resp(input logic [lbe_pkg::RAW-1:0] a);
    logic [1:0] r;
    r = lbe_pkg::RESP_DECERR;
    if (a[1:0] != 2'h0) begin
      r = lbe_pkg::RESP_SLVERR;
    end else if (a == lbe_pkg::OFF_ERROR_FLAGS ||
                 a == lbe_pkg::OFF_IRQ_ENABLES ||
                 a == lbe_pkg::OFF_CHECK_ENABLE ||
                 a == lbe_pkg::OFF_CORR_COUNT ||
                 a == lbe_pkg::OFF_CORR_FAIL_DATA ||
                 a == lbe_pkg::OFF_CORR_FAIL_CHECK ||
                 a == lbe_pkg::OFF_CORR_FAIL_ADDR ||
                 a == lbe_pkg::OFF_UNC_FAIL_DATA ||
                 a == lbe_pkg::OFF_UNC_FAIL_CHECK ||
                 a == lbe_pkg::OFF_UNC_FAIL_ADDR ||
                 a == lbe_pkg::OFF_INJECT_DATA ||
                 a == lbe_pkg::OFF_INJECT_CHECK) begin
      r = lbe_pkg::RESP_OKAY;
    end
    return r;
  endfunction : lbe_resp

  lbe_pkg::lbe_state_t state;
  lbe_pkg::lbe_req_t [lbe_pkg::NPORT-1:0] pend;
  lbe_pkg::lbe_req_t [lbe_pkg::NPORT-1:0] cur;
  lbe_pkg::lbe_req_t greq;
  lbe_pkg::lbe_req_t act;
  lbe_pkg::lbe_dec_t dec;
  logic [lbe_pkg::NPORT-1:0] pend_v;
  logic [lbe_pkg::NPORT-1:0] busy_q;
  logic [lbe_pkg::NPORT-1:0] ready_q;
  logic [lbe_pkg::PSW-1:0] gsel;
  logic [lbe_pkg::PSW-1:0] act_port;
  logic gany;
  logic issue;
  logic g_rmw;
  logic mem_write;
  logic rd_q;
  logic chk_v;
  logic ev_corr;
  logic ev_unc;
  logic [lbe_pkg::AW-1:0] last_addr;
  logic [lbe_pkg::DW-1:0] merge_q;
  logic [lbe_pkg::DW-1:0] wr_word;
  logic [lbe_pkg::DW-1:0] wmask;
  logic [1:0] flags;
  logic [1:0] next_flags;
  logic [1:0] irq_en;
  logic check_on;
  logic [lbe_pkg::CNTW-1:0] corr_count;
  logic [lbe_pkg::DW-1:0] corr_fail_data;
  logic [lbe_pkg::SYNW-1:0] corr_fail_check;
  logic [lbe_pkg::AW-1:0] corr_fail_addr;
  logic [lbe_pkg::DW-1:0] unc_fail_data;
  logic [lbe_pkg::SYNW-1:0] unc_fail_check;
  logic [lbe_pkg::AW-1:0] unc_fail_addr;
  logic [lbe_pkg::DW-1:0] inject_data;
  logic [lbe_pkg::SYNW-1:0] inject_check;
  logic aw_ack;
  logic ar_ack;
  logic [lbe_pkg::DW-1:0] rmux;

  // Lowest port number wins; losers and busy-time strobes are held
  always_comb begin
    gany = 1'b0;
    gsel = '0;
    for (int i = lbe_pkg::NPORT - 1; i >= 0; i--) begin
      cur[i] = pend_v[i] ? pend[i] : local_bus_req[i];
      if (pend_v[i] || local_bus_req[i].local_bus_address_strobe) begin
        gany = 1'b1;
        gsel = lbe_pkg::PSW'(i);
      end
    end
    greq = cur[gsel];
    issue = gany && state == lbe_pkg::ST_IDLE;
    g_rmw = greq.local_bus_write_strobe &&
            greq.local_bus_byte_enables != '1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_v <= '0;
      pend <= '0;
    end else begin
      for (int i = 0; i < lbe_pkg::NPORT; i++) begin
        if (issue && gsel == lbe_pkg::PSW'(i)) begin
          pend_v[i] <= 1'b0;
        end else if (local_bus_req[i].local_bus_address_strobe &&
                     !pend_v[i]) begin
          pend_v[i] <= 1'b1;
          pend[i] <= local_bus_req[i];
        end
      end
    end
  end

  // Partial writes need read-modify-write so the check byte covers the word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= lbe_pkg::ST_IDLE;
      act <= '0;
      act_port <= '0;
      busy_q <= '0;
      ready_q <= '0;
      rd_q <= 1'b0;
      chk_v <= 1'b0;
      merge_q <= lbe_pkg::WORD_RST;
      last_addr <= lbe_pkg::WORD_RST;
    end else begin
      ready_q <= '0;
      rd_q <= 1'b0;
      chk_v <= 1'b0;
      unique case (state)
        lbe_pkg::ST_IDLE: begin
          if (issue) begin
            last_addr <= greq.local_bus_address;
            act <= greq;
            act_port <= gsel;
            if (g_rmw) begin
              state <= lbe_pkg::ST_RMW_RD;
              busy_q <= lbe_onehot(gsel);
              chk_v <= 1'b1;
            end else begin
              ready_q <= lbe_onehot(gsel);
              rd_q <= greq.local_bus_read_strobe;
              chk_v <= greq.local_bus_read_strobe;
            end
          end
        end
        lbe_pkg::ST_RMW_RD: begin
          merge_q <=
            (dec.data & ~lbe_byte_mask(act.local_bus_byte_enables)) |
            (act.local_bus_write_data &
             lbe_byte_mask(act.local_bus_byte_enables));
          state <= lbe_pkg::ST_RMW_WR;
        end
        lbe_pkg::ST_RMW_WR: begin
          ready_q <= lbe_onehot(act_port);
          busy_q <= '0;
          state <= lbe_pkg::ST_IDLE;
        end
        default: begin
          state <= lbe_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // RAM is driven in the strobe cycle itself to keep one-cycle latency
  always_comb begin
    wr_word = (state == lbe_pkg::ST_RMW_WR) ? merge_q
                                           : greq.local_bus_write_data;
    mem_write = state == lbe_pkg::ST_RMW_WR ||
                (issue && greq.local_bus_write_strobe && !g_rmw);
    mem_en = issue || state == lbe_pkg::ST_RMW_WR;
    mem_addr = (state == lbe_pkg::ST_RMW_WR) ? act.local_bus_address
                                            : greq.local_bus_address;
    mem_we = mem_write ? '1 : '0;
    mem_dout = {1'b0, lbe_pkg::lbe_ecc_gen(wr_word) ^ inject_check,
                wr_word ^ inject_data};
    dec = lbe_pkg::lbe_ecc_dec(mem_din, check_on);
    ev_corr = chk_v && dec.corr;
    ev_unc = chk_v && dec.unc;
    for (int i = 0; i < lbe_pkg::NPORT; i++) begin
      port_read_data[i] = dec.data;
      port_correctable_flag[i] = ready_q[i] && rd_q && dec.corr;
      port_uncorrectable_flag[i] = ready_q[i] && rd_q && dec.unc;
    end
    port_ready = ready_q;
    port_wait = pend_v | busy_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      uncorrectable_error_pulse <= 1'b0;
      correctable_error_pulse <= 1'b0;
      interrupt <= 1'b0;
    end else begin
      uncorrectable_error_pulse <= ev_unc;
      correctable_error_pulse <= ev_corr;
      interrupt <= |(flags & irq_en);
    end
  end

  // Register bus: address and data taken together, one acknowledge cycle
  assign s_axi_awready = aw_ack;
  assign s_axi_wready = aw_ack;
  assign s_axi_arready = ar_ack;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_ack <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lbe_pkg::RESP_OKAY;
    end else begin
      aw_ack <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !aw_ack;
      if (aw_ack) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= lbe_resp(s_axi_awaddr);
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (s_axi_araddr)
      lbe_pkg::OFF_ERROR_FLAGS: rmux = {30'h0, flags};
      lbe_pkg::OFF_IRQ_ENABLES: rmux = {30'h0, irq_en};
      lbe_pkg::OFF_CHECK_ENABLE: rmux = {31'h0, check_on};
      lbe_pkg::OFF_CORR_COUNT: rmux = {24'h0, corr_count};
      lbe_pkg::OFF_CORR_FAIL_DATA: rmux = corr_fail_data;
      lbe_pkg::OFF_CORR_FAIL_CHECK: rmux = {25'h0, corr_fail_check};
      lbe_pkg::OFF_CORR_FAIL_ADDR: rmux = corr_fail_addr;
      lbe_pkg::OFF_UNC_FAIL_DATA: rmux = unc_fail_data;
      lbe_pkg::OFF_UNC_FAIL_CHECK: rmux = {25'h0, unc_fail_check};
      lbe_pkg::OFF_UNC_FAIL_ADDR: rmux = unc_fail_addr;
      default: rmux = lbe_pkg::WORD_RST;
    endcase
  end

  // read address is held by the master until arready
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ar_ack <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= lbe_pkg::WORD_RST;
      s_axi_rresp <= lbe_pkg::RESP_OKAY;
    end else begin
      ar_ack <= s_axi_arvalid && !s_axi_rvalid && !ar_ack;
      if (ar_ack) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux;
        s_axi_rresp <= lbe_resp(s_axi_araddr);
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // New error in the clearing cycle still sets its flag
  always_comb begin
    wmask = lbe_byte_mask(s_axi_wstrb);
    next_flags = flags;
    if (aw_ack && s_axi_awaddr == lbe_pkg::OFF_ERROR_FLAGS) begin
      next_flags = flags & ~(s_axi_wdata[1:0] & wmask[1:0]);
    end
    next_flags[lbe_pkg::FLAG_UNC_BIT] = next_flags[lbe_pkg::FLAG_UNC_BIT] |
                                        ev_unc;
    next_flags[lbe_pkg::FLAG_CORR_BIT] = next_flags[lbe_pkg::FLAG_CORR_BIT] |
                                         ev_corr;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags <= lbe_pkg::FLAGS_RST;
      irq_en <= lbe_pkg::IRQ_EN_RST;
      check_on <= lbe_pkg::CHECK_ON_RST;
      corr_count <= lbe_pkg::COUNT_RST;
    end else begin
      flags <= next_flags;
      if (aw_ack && s_axi_awaddr == lbe_pkg::OFF_IRQ_ENABLES && s_axi_wstrb[0])
      begin
        irq_en <= s_axi_wdata[1:0];
      end
      if (aw_ack && s_axi_awaddr == lbe_pkg::OFF_CHECK_ENABLE &&
          s_axi_wstrb[0]) begin
        check_on <= s_axi_wdata[lbe_pkg::CHECK_ON_BIT];
      end
      if (aw_ack && s_axi_awaddr == lbe_pkg::OFF_CORR_COUNT && s_axi_wstrb[0])
      begin
        corr_count <= s_axi_wdata[lbe_pkg::CNTW-1:0];
      end else if (ev_corr && corr_count != '1) begin
        corr_count <= corr_count + 1'b1;
      end
    end
  end

  // Captures hold the raw word; frozen until software clears the flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      corr_fail_data <= lbe_pkg::WORD_RST;
      corr_fail_check <= '0;
      corr_fail_addr <= lbe_pkg::WORD_RST;
      unc_fail_data <= lbe_pkg::WORD_RST;
      unc_fail_check <= '0;
      unc_fail_addr <= lbe_pkg::WORD_RST;
    end else begin
      if (ev_corr && !flags[lbe_pkg::FLAG_CORR_BIT]) begin
        corr_fail_data <= mem_din[lbe_pkg::DW-1:0];
        corr_fail_check <= mem_din[lbe_pkg::DW+lbe_pkg::SYNW-1:lbe_pkg::DW];
        corr_fail_addr <= last_addr;
      end
      if (ev_unc && !flags[lbe_pkg::FLAG_UNC_BIT]) begin
        unc_fail_data <= mem_din[lbe_pkg::DW-1:0];
        unc_fail_check <= mem_din[lbe_pkg::DW+lbe_pkg::SYNW-1:lbe_pkg::DW];
        unc_fail_addr <= last_addr;
      end
    end
  end

  // Injection masks apply to the next RAM write only, then self-clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inject_data <= lbe_pkg::WORD_RST;
      inject_check <= '0;
    end else begin
      if (mem_write) begin
        inject_data <= lbe_pkg::WORD_RST;
        inject_check <= '0;
      end
      if (aw_ack && s_axi_awaddr == lbe_pkg::OFF_INJECT_DATA) begin
        inject_data <= (inject_data & ~wmask) | (s_axi_wdata & wmask);
      end
      if (aw_ack && s_axi_awaddr == lbe_pkg::OFF_INJECT_CHECK &&
          s_axi_wstrb[0]) begin
        inject_check <= s_axi_wdata[lbe_pkg::SYNW-1:0];
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_unc_pulse: assert property (
    ev_unc |=> uncorrectable_error_pulse && flags[lbe_pkg::FLAG_UNC_BIT])
    else $error("uncorrectable pulse or flag missing");
  a_corr_pulse: assert property (
    !ev_corr |=> !correctable_error_pulse)
    else $error("correctable pulse without error");
  a_rmw_lanes: assert property (
    state == lbe_pkg::ST_RMW_WR |-> mem_en && mem_we == '1)
    else $error("read-modify-write lanes incomplete");
  a_read_latency: assert property (
    issue && !g_rmw |=> port_ready == lbe_onehot($past(gsel)))
    else $error("access not answered next cycle");
  a_rmw_latency: assert property (
    issue && g_rmw |=> !(|port_ready) ##1 !(|port_ready) ##1 (|port_ready))
    else $error("partial write latency wrong");
  a_strobe_lane: assert property (
    aw_ack && s_axi_awaddr == lbe_pkg::OFF_IRQ_ENABLES && !s_axi_wstrb[0]
    |=> $stable(irq_en))
    else $error("disabled lane was written");
  a_bresp_decode: assert property (
    aw_ack && s_axi_awaddr == 10'h3FC |=> s_axi_bvalid &&
    s_axi_bresp == lbe_pkg::RESP_DECERR)
    else $error("unmapped write not decode error");
  a_rresp_decode: assert property (
    ar_ack && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rvalid &&
    s_axi_rresp == lbe_pkg::RESP_SLVERR)
    else $error("unaligned read not slave error");
  a_flag_no_set: assert property (
    !flags[lbe_pkg::FLAG_UNC_BIT] && !ev_unc
    |=> !flags[lbe_pkg::FLAG_UNC_BIT])
    else $error("flag set without error");
  a_irq_gate: assert property (
    flags == 2'h0 ##1 flags == 2'h0 |-> !interrupt)
    else $error("interrupt without flag");
  a_count_sat: assert property (
    corr_count == '1 && !aw_ack |=> corr_count == '1)
    else $error("count wrapped");
  a_capture_hold: assert property (
    flags[lbe_pkg::FLAG_CORR_BIT] |=> $stable(corr_fail_addr))
    else $error("capture changed while frozen");
endmodule : lbe_ctrl

// [src/lbe_pkg.sv]
// Constants, carriers and check-code functions of the local bus RAM
// controller. Assumes one clock, with the check byte stored beside each word.
package lbe_pkg;
  localparam int DW = 32;
  localparam int AW = 32;
  localparam int NPORT = 4;
  localparam int PSW = 2;
  localparam int CHKW = 8;
  localparam int SYNW = 7;
  localparam int MW = DW + CHKW;
  localparam int NLANE = MW / 8;
  localparam int BEW = DW / 8;
  localparam int CNTW = 8;
  localparam int RAW = 10;

  localparam logic [RAW-1:0] OFF_ERROR_FLAGS = 10'h000;
  localparam logic [RAW-1:0] OFF_IRQ_ENABLES = 10'h004;
  localparam logic [RAW-1:0] OFF_CHECK_ENABLE = 10'h008;
  localparam logic [RAW-1:0] OFF_CORR_COUNT = 10'h00C;
  localparam logic [RAW-1:0] OFF_CORR_FAIL_DATA = 10'h100;
  localparam logic [RAW-1:0] OFF_CORR_FAIL_CHECK = 10'h180;
  localparam logic [RAW-1:0] OFF_CORR_FAIL_ADDR = 10'h1C0;
  localparam logic [RAW-1:0] OFF_UNC_FAIL_DATA = 10'h200;
  localparam logic [RAW-1:0] OFF_UNC_FAIL_CHECK = 10'h280;
  localparam logic [RAW-1:0] OFF_UNC_FAIL_ADDR = 10'h2C0;
  localparam logic [RAW-1:0] OFF_INJECT_DATA = 10'h300;
  localparam logic [RAW-1:0] OFF_INJECT_CHECK = 10'h380;

  localparam int FLAG_UNC_BIT = 0;
  localparam int FLAG_CORR_BIT = 1;
  localparam int CHECK_ON_BIT = 0;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  localparam logic CHECK_ON_RST = 1'b1;
  localparam logic [CNTW-1:0] COUNT_RST = 8'h00;
  localparam logic [DW-1:0] WORD_RST = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [AW-1:0] local_bus_address;
    logic [DW-1:0] local_bus_write_data;
    logic [BEW-1:0] local_bus_byte_enables;
    logic local_bus_address_strobe;
    logic local_bus_read_strobe;
    logic local_bus_write_strobe;
  } lbe_req_t;

  typedef struct packed {
    logic [DW-1:0] data;
    logic corr;
    logic unc;
  } lbe_dec_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RMW_RD = 2'h1,
    ST_RMW_WR = 2'h3
  } lbe_state_t;

  // Hamming positions 1..38, data in non-power-of-two slots, bit 6 parity
  function automatic logic [SYNW-1:0] lbe_ecc_gen(input logic [DW-1:0] d);
    logic [5:0] c;
    int k;
    c = 6'h00;
    k = 0;
    for (int pos = 1; pos <= DW + 6; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (d[k]) begin
          c = c ^ 6'(pos);
        end
        k++;
      end
    end
    return {(^d) ^ (^c), c};
  endfunction : lbe_ecc_gen

  function automatic lbe_dec_t lbe_ecc_dec(input logic [MW-1:0] raw,
                                           input logic on);
    lbe_dec_t r;
    logic [SYNW-1:0] s;
    logic par;
    int k;
    r.data = raw[DW-1:0];
    r.corr = 1'b0;
    r.unc = 1'b0;
    s = lbe_ecc_gen(raw[DW-1:0]) ^ raw[DW+SYNW-1:DW];
    par = ^raw[DW+SYNW-1:0];
    k = 0;
    if (on && par) begin
      r.corr = 1'b1;
      for (int pos = 1; pos <= DW + 6; pos++) begin
        if ((pos & (pos - 1)) != 0) begin
          if (6'(pos) == s[5:0]) begin
            r.data[k] = ~raw[k];
          end
          k++;
        end
      end
    end else if (on && s[5:0] != 6'h00) begin
      r.unc = 1'b1;
    end
    return r;
  endfunction : lbe_ecc_dec
endpackage : lbe_pkg

// [bench/lbe_ram_model.sv]
// Behavioural single-port RAM behind the controller, word plus check byte.
// Assumes one cycle read latency and byte addresses on mem_addr.
`timescale 1ns/1ps
module lbe_ram_model (
  input logic sys_clk,
  input logic mem_en,
  input logic [lbe_pkg::NLANE-1:0] mem_we,
  input logic [lbe_pkg::AW-1:0] mem_addr,
  input logic [lbe_pkg::MW-1:0] mem_dout,
  output logic [lbe_pkg::MW-1:0] mem_din
);
  logic [lbe_pkg::MW-1:0] mem [0:63];
  initial mem_din = '0;
  always @(posedge sys_clk) begin
    if (mem_en) begin
      for (int i = 0; i < lbe_pkg::NLANE; i++) begin
        if (mem_we[i]) begin
          mem[mem_addr[7:2]][8*i+:8] <= mem_dout[8*i+:8];
        end
      end
      mem_din <= mem[mem_addr[7:2]];
    end else begin
      // Output is not held between reads
      mem_din <= ~mem_din;
    end
  end
endmodule : lbe_ram_model

// [bench/lbe_ctrl_tb.sv]
// Bench for the local bus RAM controller: register bus and local ports.
// Assumes the RAM model on the memory side and one shared clock.
`timescale 1ns/1ps
module lbe_ctrl_tb;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  lbe_pkg::lbe_req_t [lbe_pkg::NPORT-1:0] req = '0;
  logic [lbe_pkg::NPORT-1:0][lbe_pkg::DW-1:0] rdata;
  logic [lbe_pkg::NPORT-1:0] rdy, cflag, uflag, pw;
  logic mem_en, irq, unc_p, ce_p, awr, wrd, bv, arr, rv;
  logic [lbe_pkg::NLANE-1:0] mem_we;
  logic [31:0] mem_addr, wdata = '0, q, axd;
  logic [lbe_pkg::MW-1:0] mem_dout, mem_din;
  logic [9:0] awa = '0, ara = '0;
  logic [3:0] strb = '0;
  logic [1:0] br, rr;
  logic awv = 1'h0, wv = 1'h0, arv = 1'h0;
  logic cf, uf;
  int errors = 0, comparisons = 0, cycles = 0, lat, ce_n = 0, unc_n = 0, c0;

  lbe_ctrl lbe_ctrl_i (.sys_clk(sys_clk), .rst(rst), .local_bus_req(req),
    .port_read_data(rdata), .port_ready(rdy), .port_wait(pw),
    .port_correctable_flag(cflag), .port_uncorrectable_flag(uflag),
    .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_dout(mem_dout), .mem_din(mem_din), .interrupt(irq),
    .uncorrectable_error_pulse(unc_p), .correctable_error_pulse(ce_p),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(axd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'h1));
  lbe_ram_model lbe_ram_model_i (.sys_clk(sys_clk), .mem_en(mem_en),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_dout(mem_dout),
    .mem_din(mem_din));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (ce_p === 1'h1) ce_n++;
    if (unc_p === 1'h1) unc_n++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] r);
    awa <= a;
    wdata <= d;
    strb <= s;
    awv <= 1'h1;
    wv <= 1'h1;
    do @(posedge sys_clk); while (awr !== 1'h1);
    awv <= 1'h0;
    wv <= 1'h0;
    do @(posedge sys_clk); while (bv !== 1'h1);
    chk(32'(br), 32'(r));
  endtask : wr

  task rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
    ara <= a;
    arv <= 1'h1;
    do @(posedge sys_clk); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge sys_clk); while (rv !== 1'h1);
    chk(32'(rr), 32'(r));
    if (r == 2'h0) chk(axd, e);
  endtask : rd

  task lb(input int p, input logic [31:0] a, input logic [31:0] d,
          input logic [3:0] be, input logic w);
    lbe_pkg::lbe_req_t r;
    r = '{a, d, be, 1'h1, ~w, w};
    req[p] <= r;
    @(posedge sys_clk);
    req[p] <= '0;
    lat = 0;
    #1;
    while (rdy[p] !== 1'h1 && lat < 20) begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
    q = rdata[p];
    cf = cflag[p];
    uf = uflag[p];
    // Let the delayed error pulse land before counting it
    repeat (3) @(posedge sys_clk);
  endtask : lb

  task report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    rd(10'h000, 32'h0, 2'h0);
    rd(10'h004, 32'h0, 2'h0);
    rd(10'h008, 32'h1, 2'h0);
    rd(10'h00C, 32'h0, 2'h0);
    rd(10'h300, 32'h0, 2'h0);
    rd(10'h010, 32'h0, 2'h3);
    rd(10'h006, 32'h0, 2'h2);
    wr(10'h3FC, 32'h0, 4'hF, 2'h3);
    wr(10'h002, 32'h0, 4'hF, 2'h2);
    // Single flipped bit on the stored word
    wr(10'h300, 32'h1, 4'hF, 2'h0);
    lb(0, 32'h10, 32'h1234_5678, 4'hF, 1'h1);
    chk(32'(lat), 32'h0);
    c0 = ce_n;
    lb(1, 32'h10, 32'h0, 4'hF, 1'h0);
    chk(32'(lat), 32'h0);
    chk(q, 32'h1234_5678);
    chk(32'({cf, uf}), 32'h2);
    chk(32'(ce_n - c0), 32'h1);
    rd(10'h000, 32'h2, 2'h0);
    rd(10'h00C, 32'h1, 2'h0);
    rd(10'h1C0, 32'h10, 2'h0);
    wr(10'h1C0, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(10'h1C0, 32'h10, 2'h0);
    // Two flipped bits cannot be repaired
    wr(10'h300, 32'h3, 4'hF, 2'h0);
    lb(2, 32'h20, 32'hCAFE_F00D, 4'hF, 1'h1);
    c0 = unc_n;
    lb(3, 32'h20, 32'h0, 4'hF, 1'h0);
    chk(32'({cf, uf}), 32'h1);
    chk(32'(unc_n - c0), 32'h1);
    rd(10'h000, 32'h3, 2'h0);
    rd(10'h2C0, 32'h20, 2'h0);
    chk(32'(irq), 32'h0);
    wr(10'h004, 32'h1, 4'hF, 2'h0);
    // Disabled lane leaves the enables alone
    wr(10'h004, 32'h3, 4'h0, 2'h0);
    rd(10'h004, 32'h1, 2'h0);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    wr(10'h000, 32'h3, 4'h0, 2'h0);
    rd(10'h000, 32'h3, 2'h0);
    wr(10'h000, 32'h1, 4'h1, 2'h0);
    rd(10'h000, 32'h2, 2'h0);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    // Counter preset to its top value must not wrap
    wr(10'h00C, 32'hFF, 4'hF, 2'h0);
    wr(10'h300, 32'h1, 4'hF, 2'h0);
    lb(0, 32'h30, 32'h1111_1111, 4'hF, 1'h1);
    lb(0, 32'h30, 32'h0, 4'hF, 1'h0);
    rd(10'h00C, 32'hFF, 2'h0);
    rd(10'h1C0, 32'h10, 2'h0);
    // Clearing the flag re-arms the capture for the next error
    wr(10'h000, 32'h2, 4'h1, 2'h0);
    // Byte write merges into the repaired word
    lb(1, 32'h30, 32'h0000_AB00, 4'h2, 1'h1);
    rd(10'h1C0, 32'h30, 2'h0);
    rd(10'h000, 32'h2, 2'h0);
    lb(1, 32'h30, 32'h0, 4'hF, 1'h0);
    chk(q, 32'h1111_AB11);
    // Two ports strobe together: lower one first, the other waits
    req[2] <= '{32'h10, 32'h0, 4'hF, 1'h1, 1'h1, 1'h0};
    req[3] <= '{32'h30, 32'h0, 4'hF, 1'h1, 1'h1, 1'h0};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk(32'({rdy, pw}), 32'h48);
    chk(rdata[2], 32'h1234_5678);
    @(posedge sys_clk);
    #1;
    chk(32'({rdy, pw}), 32'h80);
    chk(rdata[3], 32'h1111_AB11);
    repeat (3) @(posedge sys_clk);
    // With checking off the flipped bit comes back unrepaired
    wr(10'h008, 32'h0, 4'hF, 2'h0);
    rd(10'h008, 32'h0, 2'h0);
    wr(10'h300, 32'h1, 4'hF, 2'h0);
    lb(1, 32'h38, 32'hA5A5_A5A5, 4'hF, 1'h1);
    lb(1, 32'h38, 32'h0, 4'hF, 1'h0);
    chk(q, 32'hA5A5_A5A4);
    chk(32'({cf, uf}), 32'h0);
    report_and_stop();
  end
endmodule : lbe_ctrl_tb
